// *** src/pdmux_top.sv ***
// pin function multiplexer for two 8-bit ports with an axi4-lite register slave
`default_nettype none
`include "pdmux_defines.svh"

module pdmux_top #(
    parameter int T0_DEFAULT_BIT = 5,
    parameter int T0_ALT_BIT     = 7,
    parameter int T3_DEFAULT_BIT = 4,
    parameter int T3_ALT_BIT     = 7
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RESET,
    input  wire logic                 CLK_EN,
    // axi4-lite slave
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire pdmux_pkg::pdmux_addr_t S_AXI_AWADDR,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    input  wire pdmux_pkg::pdmux_word_t S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    output logic [1:0]                S_AXI_BRESP,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    input  wire pdmux_pkg::pdmux_addr_t S_AXI_ARADDR,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY,
    output pdmux_pkg::pdmux_word_t    S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    // pads
    input  wire pdmux_pkg::pdmux_byte_t PB_IN,
    output pdmux_pkg::pdmux_byte_t    PB_OUT,
    output pdmux_pkg::pdmux_byte_t    PB_OE,
    output pdmux_pkg::pdmux_byte_t    PB_PULLUP,
    output logic [1:0]                PB_ANALOG,
    input  wire pdmux_pkg::pdmux_byte_t PD_IN,
    output pdmux_pkg::pdmux_byte_t    PD_OUT,
    output pdmux_pkg::pdmux_byte_t    PD_OE,
    // peripheral side
    input  wire logic                 CCP_OUT,
    output logic                      CCP_CAPTURE_IN,
    input  wire logic [3:0]           PWM_OUT,
    input  wire logic                 PWM_SHUTDOWN,
    output logic                      PWM_FAULT_IN,
    input  wire logic                 CMP1_OUT,
    input  wire logic                 CAN_TX,
    output logic                      CAN_RX,
    input  wire logic                 SER2_TX,
    input  wire logic                 SER2_CLK_OUT,
    output logic                      SER2_CLK_IN,
    output logic [3:0]                EXT_INT,
    output logic [1:0]                TIME_EDGE_IN,
    output logic                      TIME_DELAY_IN,
    output logic                      TIMER0_CLK_IN,
    output logic                      TIMER3_CLK_IN,
    input  wire logic [6:0]           PAR_DATA_OUT,
    input  wire logic                 PAR_DRIVE,
    output logic [6:0]                PAR_DATA_IN
);
    import pdmux_pkg::*;

    // a timer clock pin index outside the 8-bit port would select a missing pad
    if (T0_DEFAULT_BIT < 0 || T0_DEFAULT_BIT > 7 || T0_ALT_BIT < 0 || T0_ALT_BIT > 7 ||
        T3_DEFAULT_BIT < 0 || T3_DEFAULT_BIT > 7 || T3_ALT_BIT < 0 || T3_ALT_BIT > 7) begin
        $error("timer clock pin index out of range");
    end

    // merges the byte lanes of a write into an 8-bit register
    function automatic pdmux_byte_t merge8(input pdmux_byte_t old, input pdmux_word_t d,
                                           input logic [3:0] s);
        merge8 = s[0] ? d[7:0] : old;
    endfunction : merge8

    // merges the byte lanes of a write into a 16-bit register
    function automatic pdmux_half_t merge16(input pdmux_half_t old, input pdmux_word_t d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ========================================
    // pad input synchronisers
    pdmux_byte_t pb_meta, pb_sync, pd_meta, pd_sync;

    // two stages so that no logic sees a metastable pad level
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pb_meta <= 8'h00;
            pb_sync <= 8'h00;
            pd_meta <= 8'h00;
            pd_sync <= 8'h00;
        end else if (CLK_EN) begin
            pb_meta <= PB_IN;
            pb_sync <= pb_meta;
            pd_meta <= PD_IN;
            pd_sync <= pd_meta;
        end
    end

    // ========================================
    // axi4-lite write channel
    pdmux_byte_t dir_b, lat_b, dir_d, lat_d;
    pdmux_half_t cfg, func;
    logic        aw_held, w_held;
    pdmux_addr_t aw_addr;
    pdmux_word_t w_data;
    logic [3:0]  w_strb;
    logic        wr_fire, wr_hit;

    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;
    assign wr_hit        = (aw_addr[11:2] <= `PDMUX_FUNC_OFS >> 2) && (aw_addr[11:5] == 7'h00);

    // address and data are caught in either order; the response follows both
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PDMUX_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? `PDMUX_RESP_OKAY : `PDMUX_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ========================================
    // control registers; level registers ignore writes
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            dir_b <= `PDMUX_DIR_RST;
            lat_b <= `PDMUX_LAT_RST;
            dir_d <= `PDMUX_DIR_RST;
            lat_d <= `PDMUX_LAT_RST;
            cfg   <= `PDMUX_CFG_RST;  // analog on both low pins after reset
            func  <= `PDMUX_FUNC_RST;
        end else if (CLK_EN && wr_fire) begin
            case ({aw_addr[11:2], 2'b00})
                `PDMUX_DIR_B_OFS: dir_b <= merge8(dir_b, w_data, w_strb);
                `PDMUX_LAT_B_OFS: lat_b <= merge8(lat_b, w_data, w_strb);
                `PDMUX_DIR_D_OFS: dir_d <= merge8(dir_d, w_data, w_strb);
                `PDMUX_LAT_D_OFS: lat_d <= merge8(lat_d, w_data, w_strb);
                `PDMUX_CFG_OFS:   cfg   <= merge16(cfg, w_data, w_strb);
                `PDMUX_FUNC_OFS:  func  <= merge16(func, w_data, w_strb);
                default: ;
            endcase
        end
    end

    // ========================================
    // axi4-lite read channel
    pdmux_byte_t lvl_b, lvl_d;
    pdmux_word_t rd_word;
    logic        rd_hit;

    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_hit        = (S_AXI_ARADDR[11:2] <= `PDMUX_FUNC_OFS >> 2) &&
                           (S_AXI_ARADDR[11:5] == 7'h00);

    // read data selection
    always_comb begin
        case ({S_AXI_ARADDR[11:2], 2'b00})
            `PDMUX_DIR_B_OFS: rd_word = {24'h00_0000, dir_b};
            `PDMUX_LAT_B_OFS: rd_word = {24'h00_0000, lat_b};
            `PDMUX_LVL_B_OFS: rd_word = {24'h00_0000, lvl_b};  // pin level readback
            `PDMUX_DIR_D_OFS: rd_word = {24'h00_0000, dir_d};
            `PDMUX_LAT_D_OFS: rd_word = {24'h00_0000, lat_d};
            `PDMUX_LVL_D_OFS: rd_word = {24'h00_0000, lvl_d};
            `PDMUX_CFG_OFS:   rd_word = {16'h0000, cfg};
            `PDMUX_FUNC_OFS:  rd_word = {16'h0000, func};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // one read at a time, answered the cycle after the address is taken
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= `PDMUX_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_word;
                S_AXI_RRESP  <= rd_hit ? `PDMUX_RESP_OKAY : `PDMUX_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ========================================
    // decoded controls
    logic       pullup_n, can_sel, t0_sel, t3_sel, par_en, ana10, ana8;
    logic       ccp_sel, pwm_en, cmp1_en, can_en, ser_en, ser_sync, ser_master;
    logic [3:0] pwm_tri, pwm_float;

    assign pullup_n   = cfg[`PDMUX_CFG_PULLUP_N];
    assign can_sel    = cfg[`PDMUX_CFG_CAN_SEL];
    assign t0_sel     = cfg[`PDMUX_CFG_T0_SEL];
    assign t3_sel     = cfg[`PDMUX_CFG_T3_SEL];
    assign pwm_tri    = cfg[`PDMUX_CFG_TRI_LO +: 4];
    assign par_en     = cfg[`PDMUX_CFG_PAR_EN];
    assign ana10      = cfg[`PDMUX_CFG_ANA10];
    assign ana8       = cfg[`PDMUX_CFG_ANA8];
    assign ccp_sel    = func[`PDMUX_FN_CCP_OUT];
    assign pwm_en     = func[`PDMUX_FN_PWM_EN];
    assign cmp1_en    = func[`PDMUX_FN_CMP1_EN];
    assign can_en     = func[`PDMUX_FN_CAN_EN];
    assign ser_en     = func[`PDMUX_FN_SER_EN];
    assign ser_sync   = func[`PDMUX_FN_SER_SYNC];
    assign ser_master = func[`PDMUX_FN_SER_MASTER];
    // a channel floats during shutdown only where its tri-state option is set
    assign pwm_float  = pwm_tri & {4{PWM_SHUTDOWN}};

    // ========================================
    // port b pad drive
    logic b2_can, b2_cmp, b3_pwm;

    assign b2_can = can_sel && can_en;   // can transmit pin
    assign b2_cmp = cmp1_en && !b2_can;  // comparator ahead of latch
    assign b3_pwm = pwm_en && !b2_can;

    assign PB_ANALOG = {ana8, ana10};
    assign PB_OUT[0] = lat_b[0];
    assign PB_OUT[1] = lat_b[1];
    assign PB_OUT[2] = b2_can ? CAN_TX : (b2_cmp ? CMP1_OUT : lat_b[2]);
    assign PB_OUT[3] = b3_pwm ? PWM_OUT[3] : lat_b[3];
    assign PB_OUT[7:4] = lat_b[7:4];

    // analog pins never drive; the pwm d pin floats on a gated shutdown
    assign PB_OE[0] = !dir_b[0] && !ana10;
    assign PB_OE[1] = !dir_b[1] && !ana8;
    assign PB_OE[2] = !dir_b[2];
    assign PB_OE[3] = !dir_b[3] && !(b3_pwm && pwm_float[3]);
    assign PB_OE[7:4] = ~dir_b[7:4];

    // weak pull-up only on input pins and only while the enable is low
    assign PB_PULLUP = pullup_n ? 8'h00 : dir_b;

    // digital readback reads zero on an analog pin
    assign lvl_b = pb_sync & {6'h3F, ~ana8, ~ana10};

    // ========================================
    // port d pad drive
    logic       d4_ccp, d6_ser_tx, d6_ser_clk;
    logic [6:0] d_func_out;
    logic [6:0] d_float;

    assign d4_ccp     = ccp_sel || pwm_en;
    assign d6_ser_tx  = ser_en && !ser_sync;
    assign d6_ser_clk = ser_en && ser_sync && ser_master;

    assign d_func_out[3:0] = lat_d[3:0];
    assign d_func_out[4]   = pwm_en ? PWM_OUT[0] : (ccp_sel ? CCP_OUT : lat_d[4]);
    assign d_func_out[5]   = pwm_en ? PWM_OUT[1] : lat_d[5];
    assign d_func_out[6]   = d6_ser_tx ? SER2_TX :
                             (d6_ser_clk ? SER2_CLK_OUT :
                             (pwm_en ? PWM_OUT[2] : lat_d[6]));
    assign d_float = {pwm_en && !ser_en && pwm_float[2], pwm_en && pwm_float[1],
                      d4_ccp && pwm_en && pwm_float[0], 4'h0};

    // parallel port owns bits 0 to 6 and ignores the direction bits
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_pd
            assign PD_OUT[gi] = par_en ? PAR_DATA_OUT[gi] : d_func_out[gi];
            assign PD_OE[gi]  = par_en ? PAR_DRIVE : (!dir_d[gi] && !d_float[gi]);
        end
    endgenerate
    assign PD_OUT[7] = lat_d[7];
    assign PD_OE[7]  = !dir_d[7];
    assign lvl_d     = pd_sync;

    // ========================================
    // peripheral inputs taken from synchronised pad levels
    assign CCP_CAPTURE_IN = dir_d[4] && pd_sync[4];           // capture only as input
    assign PWM_FAULT_IN   = pb_sync[0];                       // no direction dependence
    assign TIME_EDGE_IN   = {pb_sync[3], pb_sync[2]};
    assign TIME_DELAY_IN  = pb_sync[1] && !ana8;
    assign EXT_INT        = pb_sync[3:0] & {2'b11, ~ana8, ~ana10};  // direction set by software
    assign CAN_RX         = can_sel ? pb_sync[3] : 1'b1;      // idle recessive when unrouted
    assign SER2_CLK_IN    = pd_sync[6];                       // slave clock input
    assign PAR_DATA_IN    = pd_sync[6:0];
    assign TIMER0_CLK_IN  = t0_sel ? pb_sync[T0_DEFAULT_BIT] : pd_sync[T0_ALT_BIT];
    assign TIMER3_CLK_IN  = t3_sel ? pb_sync[T3_DEFAULT_BIT] : pd_sync[T3_ALT_BIT];

    // ========================================
    // checks beside the logic they guard
    property p_pullup;
        @(posedge CORE_CLK) disable iff (RESET)
        (!pullup_n && dir_b[5]) |-> PB_PULLUP[5] && !PB_OE[5];
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up missing on input pin");

    property p_analog_reset;
        @(posedge CORE_CLK) $fell(RESET) |-> PB_ANALOG == 2'b11 && PB_OE[1:0] == 2'b00;
    endproperty
    a_analog_reset: assert property (p_analog_reset) else $error("low pins not analog");

    property p_ccp_override;
        @(posedge CORE_CLK) disable iff (RESET)
        (ccp_sel && !pwm_en && !par_en && !dir_d[4]) |-> PD_OE[4] && PD_OUT[4] == CCP_OUT;
    endproperty
    a_ccp_override: assert property (p_ccp_override) else $error("compare output lost");

    property p_pwm_float;
        @(posedge CORE_CLK) disable iff (RESET)
        (pwm_en && !par_en && pwm_tri[0] && PWM_SHUTDOWN) |-> !PD_OE[4];
    endproperty
    a_pwm_float: assert property (p_pwm_float) else $error("pwm pin drives in shutdown");

    property p_par_dir;
        @(posedge CORE_CLK) disable iff (RESET)
        par_en |-> PD_OE[6:0] == {7{PAR_DRIVE}} && PD_OUT[6:0] == PAR_DATA_OUT;
    endproperty
    a_par_dir: assert property (p_par_dir) else $error("parallel port not in control");

    property p_can_route;
        @(posedge CORE_CLK) disable iff (RESET)
        (can_sel && can_en && !dir_b[2]) |-> PB_OE[2] && PB_OUT[2] == CAN_TX;
    endproperty
    a_can_route: assert property (p_can_route) else $error("can transmit not routed");

    property p_cmp_prio;
        @(posedge CORE_CLK) disable iff (RESET)
        (cmp1_en && !b2_can && !dir_b[2]) |-> PB_OUT[2] == CMP1_OUT;
    endproperty
    a_cmp_prio: assert property (p_cmp_prio) else $error("comparator lost to latch");

    property p_ser_tx;
        @(posedge CORE_CLK) disable iff (RESET)
        (ser_en && !ser_sync && !par_en && !dir_d[6]) |-> PD_OE[6] && PD_OUT[6] == SER2_TX;
    endproperty
    a_ser_tx: assert property (p_ser_tx) else $error("serial transmit lost");

    property p_level_read;
        @(posedge CORE_CLK) disable iff (RESET || !CLK_EN)
        (CLK_EN && !RESET) [*3] |-> lvl_d == $past(PD_IN, 2);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level readback stale");

    property p_timer_sel;
        @(posedge CORE_CLK) disable iff (RESET)
        ((CLK_EN && !RESET) [*3]) ##0 t0_sel |->
            TIMER0_CLK_IN == $past(PB_IN[T0_DEFAULT_BIT], 2);
    endproperty
    a_timer_sel: assert property (p_timer_sel) else $error("timer 0 pin wrong");

endmodule : pdmux_top
`default_nettype wire

// *** src/pdmux_defines.svh ***
// register map, reset values, field positions and bus codes of the port b/d pin mux
`ifndef PDMUX_DEFINES_SVH
`define PDMUX_DEFINES_SVH
// ========================================
// register byte offsets
`define PDMUX_DIR_B_OFS     12'h000
`define PDMUX_LAT_B_OFS     12'h004
`define PDMUX_LVL_B_OFS     12'h008
`define PDMUX_DIR_D_OFS     12'h00C
`define PDMUX_LAT_D_OFS     12'h010
`define PDMUX_LVL_D_OFS     12'h014
`define PDMUX_CFG_OFS       12'h018
`define PDMUX_FUNC_OFS      12'h01C
// ========================================
// reset values
`define PDMUX_DIR_RST       8'hFF
`define PDMUX_LAT_RST       8'h00
`define PDMUX_CFG_RST       16'h060F
`define PDMUX_FUNC_RST      16'h0000
// ========================================
// configuration register fields
`define PDMUX_CFG_PULLUP_N  0
`define PDMUX_CFG_CAN_SEL   1
`define PDMUX_CFG_T0_SEL    2
`define PDMUX_CFG_T3_SEL    3
`define PDMUX_CFG_TRI_LO    4
`define PDMUX_CFG_PAR_EN    8
`define PDMUX_CFG_ANA10     9
`define PDMUX_CFG_ANA8      10
// ========================================
// function register fields
`define PDMUX_FN_CCP_OUT    0
`define PDMUX_FN_PWM_EN     1
`define PDMUX_FN_CMP1_EN    2
`define PDMUX_FN_CAN_EN     3
`define PDMUX_FN_SER_EN     4
`define PDMUX_FN_SER_SYNC   5
`define PDMUX_FN_SER_MASTER 6
// ========================================
// axi response codes
`define PDMUX_RESP_OKAY     2'b00
`define PDMUX_RESP_SLVERR   2'b10
`endif

// *** src/pdmux_pkg.sv ***
// shared types of the port b/d pin mux
`default_nettype none
package pdmux_pkg;
    typedef logic [7:0]  pdmux_byte_t;
    typedef logic [15:0] pdmux_half_t;
    typedef logic [31:0] pdmux_word_t;
    typedef logic [11:0] pdmux_addr_t;
endpackage : pdmux_pkg
`default_nettype wire

// *** sim/pdmux_board.sv ***
// board model: pad wires and external drivers of ports b and d, pull-ups of port b only
`default_nettype none
module pdmux_board (
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_pu,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_be,
    input  wire logic [7:0] ext_d,
    input  wire logic [7:0] ext_de,
    input  wire logic       clk,
    output logic      [7:0] pb_in,
    output logic      [7:0] pd_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flip = 8'h55;
    // ========================================
    // floating pads toggle so a stale level never passes for a real one
    always @(posedge clk) flip <= ~flip;
    // device drive wins, then the board driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pb_in[i] = pb_oe[i] ? pb_out[i] : ext_be[i] ? ext_b[i] : pb_pu[i] | flip[i];
            pd_in[i] = pd_oe[i] ? pd_out[i] : ext_de[i] ? ext_d[i] : flip[i];
        end
    end
endmodule : pdmux_board
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the port b/d pin mux
`default_nettype none
`include "pdmux_defines.svh"
module tb;
    import pdmux_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrd, bv, arr, rv, cap, flt, can_rx, ck_in, t0, t3, dly;
    logic ccp = 0, cmp = 0, can_tx = 0, ser_tx = 0, ser_ck = 0, shut = 0, par_drv = 0;
    logic [1:0] br, rr, resp, pb_an, edge_in;
    logic [3:0] pwm = 4'h0, ext_int;
    logic [6:0] par_out = 7'h00, par_in;
    pdmux_addr_t awa = 12'h000, ara = 12'h000;
    pdmux_word_t wd = 32'h0000_0000, rdat, x, v;
    pdmux_byte_t pb_in, pb_out, pb_oe, pb_pu, pd_in, pd_out, pd_oe, e;
    pdmux_byte_t ext_b = 8'h00, ext_be = 8'h00, ext_d = 8'h00, ext_de = 8'h00;
    integer failures = 0, cmp_count = 0, seed = 32'hA2B5_CC2F;
    // ========================================
    // design and board
    pdmux_top u_dut (.CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bre), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rr), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PB_PULLUP(pb_pu),
        .PB_ANALOG(pb_an), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE(pd_oe), .CCP_OUT(ccp),
        .CCP_CAPTURE_IN(cap), .PWM_OUT(pwm), .PWM_SHUTDOWN(shut), .PWM_FAULT_IN(flt),
        .CMP1_OUT(cmp), .CAN_TX(can_tx), .CAN_RX(can_rx), .SER2_TX(ser_tx),
        .SER2_CLK_OUT(ser_ck), .SER2_CLK_IN(ck_in), .EXT_INT(ext_int), .TIME_EDGE_IN(edge_in),
        .TIME_DELAY_IN(dly), .TIMER0_CLK_IN(t0), .TIMER3_CLK_IN(t3),
        .PAR_DATA_OUT(par_out), .PAR_DRIVE(par_drv), .PAR_DATA_IN(par_in));
    pdmux_board u_board (.pb_out(pb_out), .pb_oe(pb_oe), .pb_pu(pb_pu), .pd_out(pd_out),
        .pd_oe(pd_oe), .ext_b(ext_b), .ext_be(ext_be), .ext_d(ext_d), .ext_de(ext_de),
        .clk(clk), .pb_in(pb_in), .pd_in(pd_in));
    // ========================================
    // helpers
    task automatic finish_test(input bit to);
        if (to) failures++;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // ready is sampled at the falling edge, where it already equals its value at the next rise
    task automatic wr(input pdmux_addr_t a, input pdmux_word_t d);
        int n;
        logic sa, sw, sb;
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bre <= 1'b1;
        n = 0;
        sb = 0;
        while (!sb && n < 50) begin
            @(negedge clk);
            sa = awv & awr;
            sw = wv & wrd;
            sb = bv;
            resp = br;
            @(posedge clk);
            if (sa) awv <= 1'b0;
            if (sw) wv <= 1'b0;
            n++;
        end
        bre <= 1'b0;
        if (!sb) finish_test(1);
    endtask : wr
    task automatic rd(input pdmux_addr_t a);
        int n;
        logic sa, sr;
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        n = 0;
        sr = 0;
        while (!sr && n < 50) begin
            @(negedge clk);
            sa = arr;
            sr = rv;
            x = rdat;
            resp = rr;
            @(posedge clk);
            if (sa) arv <= 1'b0;
            n++;
        end
        rre <= 1'b0;
        if (!sr) finish_test(1);
    endtask : rd
    // pin inputs pass two synchroniser flops
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle
    function automatic logic exp_b2(logic [2:0] s, logic ctx, logic cmo, logic lat);
        return (s[2] & s[1]) ? ctx : s[0] ? cmo : lat;
    endfunction : exp_b2
    // ========================================
    // clock and main sequence
    initial forever #2.5 clk = ~clk;
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`PDMUX_DIR_B_OFS);
        chk("dir_b", x, 32'h0000_00FF);
        rd(`PDMUX_CFG_OFS);
        chk("cfg", x, 32'h0000_060F);
        chk("analog", pb_an, 2'b11);
        v = $random(seed);
        wr(`PDMUX_LAT_B_OFS, v);
        wr(`PDMUX_DIR_B_OFS, 32'h0000_0000);
        @(negedge clk);
        chk("oe_b analog", pb_oe, 8'hFC);
        chk("out_b", pb_out[7:2], v[7:2]);
        wr(`PDMUX_CFG_OFS, 32'h0000_000E);
        @(negedge clk);
        chk("oe_b", pb_oe, 8'hFF);
        chk("out_b all", pb_out, v[7:0]);
        wr(`PDMUX_DIR_B_OFS, 32'h0000_00FF);
        e = 8'($random(seed));
        ext_b <= e;
        ext_be <= 8'h3F;
        settle();
        chk("pullup", pb_pu, 8'hFF);
        rd(`PDMUX_LVL_B_OFS);
        chk("lvl_b", x, {24'h00_0000, 2'b11, e[5:0]});
        chk("ext_int", ext_int, e[3:0]);
        chk("fault edge", {flt, edge_in}, {e[0], e[3], e[2]});
        chk("timer clk", {t0, t3}, {e[5], e[4]});
        chk("delay in", dly, e[1]);
        $display("test port b pins done");
        wr(`PDMUX_DIR_B_OFS, 32'h0000_0008);
        for (int i = 0; i < 8; i++) begin
            wr(`PDMUX_CFG_OFS, {28'h000_0000, 2'b00, i[2], 1'b0});
            wr(`PDMUX_FUNC_OFS, {28'h000_0000, i[1], i[0], 2'b00});
            can_tx <= 1'($random(seed));
            cmp <= 1'($random(seed));
            settle();
            chk("b2 mux", pb_out[2], exp_b2(i[2:0], can_tx, cmp, v[2]));
            chk("b2 oe", pb_oe[2], 1'b1);
            chk("can rx", can_rx, i[2] ? e[3] : 1'b1);
        end
        $display("test port b mux done");
        wr(`PDMUX_DIR_D_OFS, 32'h0000_0000);
        wr(`PDMUX_FUNC_OFS, 32'h0000_0001);
        ccp <= 1'($random(seed));
        ser_tx <= 1'($random(seed));
        ser_ck <= 1'($random(seed));
        pwm <= 4'($random(seed));
        @(negedge clk);
        chk("compare out", pd_out[4], ccp);
        wr(`PDMUX_FUNC_OFS, 32'h0000_0010);
        @(negedge clk);
        chk("serial tx", pd_out[6], ser_tx);
        wr(`PDMUX_FUNC_OFS, 32'h0000_0070);
        @(negedge clk);
        chk("serial clk out", {pd_oe[6], pd_out[6]}, {1'b1, ser_ck});
        wr(`PDMUX_CFG_OFS, 32'h0000_0010);
        wr(`PDMUX_FUNC_OFS, 32'h0000_0002);
        shut <= 1'b1;
        @(negedge clk);
        chk("pwm float", pd_oe[5:4], 2'b10);
        @(posedge clk);
        shut <= 1'b0;
        @(negedge clk);
        chk("pwm a", {pd_oe[4], pd_out[4]}, {1'b1, pwm[0]});
        e = 8'($random(seed));
        ext_d <= e;
        ext_de <= 8'h50;
        wr(`PDMUX_FUNC_OFS, 32'h0000_0030);
        wr(`PDMUX_DIR_D_OFS, 32'h0000_0050);
        settle();
        chk("capture", cap, e[4]);
        chk("serial clk in", {pd_oe[6], ck_in}, {1'b0, e[6]});
        $display("test port d done");
        wr(`PDMUX_FUNC_OFS, 32'h0000_0000);
        wr(`PDMUX_CFG_OFS, 32'h0000_0100);
        wr(`PDMUX_DIR_D_OFS, 32'h0000_00FF);
        par_out <= 7'($random(seed));
        par_drv <= 1'b1;
        @(negedge clk);
        chk("par drive", {pd_oe[6:0], pd_out[6:0]}, {7'h7F, par_out});
        @(posedge clk);
        par_drv <= 1'b0;
        ext_de <= 8'hFF;
        settle();
        chk("par in", {pd_oe[6:0], par_in}, {7'h00, e[6:0]});
        chk("timer alt", {t0, t3}, {e[7], e[7]});
        wr(12'h020, 32'h0000_00FF);
        chk("bad wr resp", resp, `PDMUX_RESP_SLVERR);
        rd(12'h020);
        chk("bad rd resp", resp, `PDMUX_RESP_SLVERR);
        chk("bad rd data", x, 32'h0000_0000);
        $display("test parallel and bus done");
        finish_test(0);
    end
endmodule : tb
`default_nettype wire
